// File: hdl/rxeq_ctrl.sv
// module: receiver eq select control top with strap latch and register port
`timescale 1ns/10ps
module rxeq_ctrl
	import rxeq_pkg::*;
#(
	parameter int SETTLE = SETTLE_CYC
)
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// enable pin, four-level straps and the two-level adaptive enable strap
	input wire logic en_i,
	input wire rxeq_level_t mode_strap_i,
	input wire rxeq_level_t conn_eq_strap_high_i,
	input wire rxeq_level_t conn_eq_strap_low_i,
	input wire rxeq_level_t host_eq_strap_high_i,
	input wire rxeq_level_t host_eq_strap_low_i,
	input wire logic adaptive_enable_n_strap_i,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	// connector lane measurements
	input wire rxeq_meas_s [LANES-1:0] conn_meas_i,
	// applied settings
	output logic [IDX_W-1:0] conn_rx1_eq_index_o,
	output logic [IDX_W-1:0] conn_rx2_eq_index_o,
	output logic [IDX_W-1:0] host_rx_eq_index_o,
	output logic [1:0] tx_linearity_o,
	output logic tx_linear_mode_o,
	output logic strap_bias_off_o,
	output logic mode_reserved_o
);
	logic [1:0] rst_sync_r;
	logic rst_n;
	rxeq_state_s s_r;
	rxeq_state_s s_nxt;
	logic [LANES-1:0] sw_busy;
	logic [LANES-1:0] sw_found;
	logic [LANES-1:0][IDX_W-1:0] sw_idx;
	logic [LANES-1:0] sw_start;
	logic [LANES-1:0] fast_start;
	logic reg_mode;
	logic full_on;

	// offset the adapted index, saturating at both ends instead of wrapping
	function automatic logic [IDX_W-1:0] adj_index(input logic [IDX_W-1:0] idx,
		input logic [IDX_W-1:0] amt, input logic sub);
		logic [IDX_W:0] sum;
		sum = {1'b0, idx} + {1'b0, amt};
		if (sub)
			adj_index = (amt > idx) ? '0 : IDX_W'(idx - amt); // R8 R10
		else if (sum > {1'b0, IDX_MAX})
			adj_index = IDX_MAX; // R9
		else
			adj_index = sum[IDX_W-1:0]; // R7
	endfunction

	// two four-level strap digits make one index, the upper pin weighs four
	function automatic logic [IDX_W-1:0] strap_index(input rxeq_level_t hi,
		input rxeq_level_t lo);
		strap_index = {hi, lo};
	endfunction

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// register mode only once straps are latched and the mode strap reads F
	assign reg_mode = s_r.latched && (s_r.mode == LVL_F); // R21
	assign full_on = s_r.latched && (reg_mode ? s_r.full_en : !s_r.aeq_n); // R11

	// one sweep engine per connector lane keeps the lanes independent
	genvar gl;
	generate
		for (gl = 0; gl < LANES; gl++)
		begin : g_lane
			assign sw_start[gl] = conn_meas_i[gl].start && full_on;
			// fast path is gated off outside register mode
			assign fast_start[gl] = conn_meas_i[gl].start && !full_on && reg_mode &&
				s_r.fast_en && s_r.ovr; // R15
			rxeq_sweep #(
				.SETTLE(SETTLE)
			) u_sweep (
				.clk_i(ref_clk_i),
				.rst_n_i(rst_n),
				.start_i(sw_start[gl]),
				.upper_i(s_r.upper),
				.eye_valid_i(conn_meas_i[gl].valid),
				.eye_i(conn_meas_i[gl].eye),
				.busy_o(sw_busy[gl]),
				.found_o(sw_found[gl]),
				.idx_o(sw_idx[gl])
			);
		end
	endgenerate

	// next state: strap latch, register writes, fast judgement, selection
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.en_d = en_i;
		s_nxt.rdata = '0;
		// straps are caught once per enable rise; bias can then be switched off
		if (en_i && !s_r.en_d)
		begin
			s_nxt.latched = 1'b1; // R20
			s_nxt.mode = mode_strap_i;
			s_nxt.conn_hi = conn_eq_strap_high_i;
			s_nxt.conn_lo = conn_eq_strap_low_i;
			s_nxt.host_hi = host_eq_strap_high_i;
			s_nxt.host_lo = host_eq_strap_low_i;
			s_nxt.aeq_n = adaptive_enable_n_strap_i;
		end
		// register writes
		if (reg_wr_i)
		begin
			case (reg_addr_i)
				REG_CONN1_SEL: s_nxt.conn_sel[0] = reg_wdata_i[IDX_W-1:0]; // R4
				REG_CONN2_SEL: s_nxt.conn_sel[1] = reg_wdata_i[IDX_W-1:0]; // R4
				REG_HOST_SEL: s_nxt.host_sel = reg_wdata_i[IDX_W-1:0]; // R4
				REG_LONG_SEL:
				begin
					s_nxt.long_sel[0] = reg_wdata_i[LONG1_LSB +: IDX_W];
					s_nxt.long_sel[1] = reg_wdata_i[LONG2_LSB +: IDX_W];
				end
				REG_CTRL:
				begin
					s_nxt.full_en = reg_wdata_i[CTRL_FULL_BIT];
					s_nxt.fast_en = reg_wdata_i[CTRL_FAST_BIT];
					s_nxt.ovr = reg_wdata_i[CTRL_OVR_BIT];
					s_nxt.sign = reg_wdata_i[CTRL_SIGN_BIT];
					s_nxt.lin = reg_wdata_i[CTRL_LIN_LSB +: 2]; // R19
				end
				REG_SWEEP:
				begin
					s_nxt.upper = reg_wdata_i[SWEEP_UPPER_LSB +: IDX_W]; // R6
					s_nxt.ofs = reg_wdata_i[SWEEP_OFS_LSB +: IDX_W];
				end
				REG_LIMITS: s_nxt.limits = reg_wdata_i; // R14
				default:
				begin
				end
			endcase
		end
		// register reads; unmapped offsets and spare bits read zero
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				REG_CONN1_SEL: s_nxt.rdata = DATA_W'(s_r.conn_sel[0]);
				REG_CONN2_SEL: s_nxt.rdata = DATA_W'(s_r.conn_sel[1]);
				REG_HOST_SEL: s_nxt.rdata = DATA_W'(s_r.host_sel);
				REG_LONG_SEL: s_nxt.rdata = {s_r.long_sel[1], s_r.long_sel[0]};
				REG_CTRL: s_nxt.rdata = {2'h0, s_r.lin, s_r.sign, s_r.ovr, s_r.fast_en,
					s_r.full_en};
				REG_SWEEP: s_nxt.rdata = {s_r.ofs, s_r.upper};
				REG_LIMITS: s_nxt.rdata = s_r.limits;
				REG_CONN1_OUT: s_nxt.rdata = DATA_W'(s_r.conn_out[0]);
				REG_CONN2_OUT: s_nxt.rdata = DATA_W'(s_r.conn_out[1]);
				REG_HOST_OUT: s_nxt.rdata = DATA_W'(s_r.host_out);
				REG_STATUS: s_nxt.rdata = {2'h0, s_r.latched, reg_mode, s_r.fast_short,
					sw_busy};
				default: s_nxt.rdata = '0;
			endcase
		end
		// fast adaptation: judge the first eye estimate after insertion
		for (int l = 0; l < LANES; l++)
		begin
			if (s_r.fast_wait[l] && conn_meas_i[l].valid)
			begin
				s_nxt.fast_wait[l] = 1'b0;
				s_nxt.fast_short[l] = (conn_meas_i[l].eye >= s_r.limits); // R14
			end
			// a new insertion restarts the judgement, it wins over completion
			if (fast_start[l])
			begin
				s_nxt.fast_wait[l] = 1'b1;
				s_nxt.fast_short[l] = 1'b1;
			end
		end
		// connector lane selection, each lane on its own
		for (int l = 0; l < LANES; l++)
		begin
			if (!s_r.latched)
				s_nxt.conn_out[l] = '0;
			else if (full_on)
				s_nxt.conn_out[l] = sw_busy[l] ? sw_idx[l] :
					(sw_found[l] ? adj_index(sw_idx[l], s_r.ofs, s_r.sign) : '0); // R7 R8
			else if (reg_mode && s_r.ovr) // R16
			begin
				if (s_r.fast_en && !s_r.fast_short[l])
					s_nxt.conn_out[l] = s_r.long_sel[l]; // R13
				else
					s_nxt.conn_out[l] = s_r.conn_sel[l]; // R12 R1
			end
			else
				s_nxt.conn_out[l] = strap_index(s_r.conn_hi, s_r.conn_lo); // R2
		end
		// host lane has fixed equalization only
		if (reg_mode && s_r.ovr)
			s_nxt.host_out = s_r.host_sel; // R4 R1
		else
			s_nxt.host_out = strap_index(s_r.host_hi, s_r.host_lo); // R3
		// strap mode pins linearity at the top setting
		s_nxt.lin_out = reg_mode ? s_r.lin : LIN_HIGHEST; // R19
		s_nxt.linear = 1'b1; // R18
	end

	// state register; reset values give the default sweep and linearity
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_r <= '0;
			s_r.upper <= RST_SWEEP_UPPER; // R6
			s_r.limits <= RST_EYE_LIMITS;
			s_r.lin <= LIN_HIGHEST; // R18
			s_r.lin_out <= LIN_HIGHEST;
			s_r.linear <= 1'b1; // R18
			s_r.fast_short <= '1;
		end
		else
			s_r <= s_nxt;
	end

	// outputs straight from the state register
	assign reg_rdata_o = s_r.rdata;
	assign conn_rx1_eq_index_o = s_r.conn_out[0];
	assign conn_rx2_eq_index_o = s_r.conn_out[1];
	assign host_rx_eq_index_o = s_r.host_out;
	assign tx_linearity_o = s_r.lin_out;
	assign tx_linear_mode_o = s_r.linear;
	assign strap_bias_off_o = s_r.latched; // R20
	assign mode_reserved_o = s_r.latched && (s_r.mode == LVL_R || s_r.mode == LVL_1);

	// checks of the selection behaviour
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n);

	strap_latch_a: assert property ($rose(en_i) |=> s_r.latched && // R20
		s_r.conn_hi == $past(conn_eq_strap_high_i))
		else $error("strap not latched on enable rise");
	strap_conn_a: assert property (s_r.latched && !reg_mode && !full_on |=> // R2
		conn_rx1_eq_index_o == {$past(s_r.conn_hi), $past(s_r.conn_lo)})
		else $error("connector strap index wrong");
	strap_host_a: assert property (s_r.latched && !reg_mode |=> // R3
		host_rx_eq_index_o == {$past(s_r.host_hi), $past(s_r.host_lo)})
		else $error("host strap index wrong");
	lin_strap_a: assert property (s_r.latched && !reg_mode |=> // R19
		tx_linearity_o == LIN_HIGHEST)
		else $error("strap mode linearity not highest");
	// watches the judgement register, so a leak in the start gating shows up
	fast_strap_a: assert property (!reg_mode && s_r.fast_wait == '0 |=> // R15
		s_r.fast_wait == '0)
		else $error("fast adaptation started in strap mode");
	offset_add_a: assert property (full_on && !sw_busy[0] && sw_found[0] && !s_r.sign // R7
		&& ({1'b0, sw_idx[0]} + {1'b0, s_r.ofs} <= 5'h0F) |=>
		conn_rx1_eq_index_o == $past(sw_idx[0]) + $past(s_r.ofs))
		else $error("offset not added");
	offset_sat_a: assert property (full_on && !sw_busy[0] && sw_found[0] && !s_r.sign // R9
		&& ({1'b0, sw_idx[0]} + {1'b0, s_r.ofs} > 5'h0F) |=>
		conn_rx1_eq_index_o == IDX_MAX)
		else $error("offset sum not saturated");
	offset_clamp_a: assert property (full_on && !sw_busy[0] && sw_found[0] && s_r.sign // R10
		&& s_r.ofs > sw_idx[0] |=> conn_rx1_eq_index_o == '0)
		else $error("offset difference not clamped");
	long_sel_a: assert property (reg_mode && s_r.ovr && s_r.fast_en && !full_on && // R13
		!s_r.fast_short[1] |=> conn_rx2_eq_index_o == $past(s_r.long_sel[1]))
		else $error("long channel field not applied");
	short_judge_a: assert property (s_r.fast_wait[0] && conn_meas_i[0].valid && // R14
		!fast_start[0] |=> s_r.fast_short[0] == ($past(conn_meas_i[0].eye) >=
		$past(s_r.limits)))
		else $error("short channel judgement wrong");
	read_lat_a: assert property (reg_rd_i && reg_addr_i == REG_SWEEP |=> // R6
		reg_rdata_o == {$past(s_r.ofs), $past(s_r.upper)})
		else $error("sweep register read wrong");

	strap_mode_c: cover property ($rose(s_r.latched) ##1 !reg_mode);
	sweep_done_c: cover property ($fell(sw_busy[0]) && full_on);
	fast_long_c: cover property ($fell(s_r.fast_short[0]));
	reg_mode_c: cover property ($rose(reg_mode));
endmodule

// File: hdl/rxeq_pkg.sv
// package: constants, register map and state types of the receiver eq select control
// How it works
// R1: each receiver lane has its own setting
// R2: connector straps give index, upper pin high
// R3: host straps form index the same way
// R4: register fields select index per lane
// R5: sweep from zero to limit, keep best
// R6: sweep limit resets to eight, nine indices
// R7: sign zero adds offset to adapted index
// R8: sign one subtracts offset from adapted index
// R9: sum saturates at fifteen
// R10: difference clamps at zero
// R11: full adaptation in both modes, strap enable
// R12: fast short channel uses lane field
// R13: fast long channel uses long field
// R14: eye height against programmable limits field
// R15: fast adaptation only in register mode
// R16: lane fields apply only with override set
// R17: integrator tunes short and long fields
// R18: transmitters reset to linear output mode
// R19: four linearity settings, strap forces highest
// R20: straps latched on enable rising edge
// R21: mode strap picks strap or register mode
package rxeq_pkg;
	localparam int IDX_W = 4;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;
	localparam int EYE_W = 8;
	localparam int LANES = 2;
	localparam int CNT_W = 16;

	// four-level strap codes
	typedef logic [1:0] rxeq_level_t;
	localparam rxeq_level_t LVL_0 = 2'h0;
	localparam rxeq_level_t LVL_R = 2'h1;
	localparam rxeq_level_t LVL_F = 2'h2;
	localparam rxeq_level_t LVL_1 = 2'h3;

	// register offsets
	localparam logic [ADDR_W-1:0] REG_CONN1_SEL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_CONN2_SEL = 4'h1;
	localparam logic [ADDR_W-1:0] REG_HOST_SEL = 4'h2;
	localparam logic [ADDR_W-1:0] REG_LONG_SEL = 4'h3;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h4;
	localparam logic [ADDR_W-1:0] REG_SWEEP = 4'h5;
	localparam logic [ADDR_W-1:0] REG_LIMITS = 4'h6;
	localparam logic [ADDR_W-1:0] REG_CONN1_OUT = 4'h8;
	localparam logic [ADDR_W-1:0] REG_CONN2_OUT = 4'h9;
	localparam logic [ADDR_W-1:0] REG_HOST_OUT = 4'hA;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'hB;

	// field positions
	localparam int CTRL_FULL_BIT = 0;
	localparam int CTRL_FAST_BIT = 1;
	localparam int CTRL_OVR_BIT = 2;
	localparam int CTRL_SIGN_BIT = 3;
	localparam int CTRL_LIN_LSB = 4;
	localparam int SWEEP_UPPER_LSB = 0;
	localparam int SWEEP_OFS_LSB = 4;
	localparam int LONG1_LSB = 0;
	localparam int LONG2_LSB = 4;

	// reset values and the top index
	localparam logic [IDX_W-1:0] RST_SWEEP_UPPER = 4'h8;
	localparam logic [EYE_W-1:0] RST_EYE_LIMITS = 8'h40;
	localparam logic [1:0] LIN_HIGHEST = 2'h3;
	localparam logic [IDX_W-1:0] IDX_MAX = 4'hF;

	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// measurement bundle from the analog front end of one connector lane
	typedef struct packed {
		logic start;
		logic valid;
		logic [EYE_W-1:0] eye;
	} rxeq_meas_s;

	typedef enum logic [1:0] {SW_IDLE, SW_SETTLE, SW_MEASURE} rxeq_sweep_e;

	typedef struct packed {
		rxeq_sweep_e st;
		logic [CNT_W-1:0] cnt;
		logic [IDX_W-1:0] idx;
		logic [IDX_W-1:0] best;
		logic [EYE_W-1:0] best_eye;
		logic found;
	} rxeq_sweep_s;

	typedef struct packed {
		logic en_d;
		logic latched;
		rxeq_level_t mode;
		rxeq_level_t conn_hi;
		rxeq_level_t conn_lo;
		rxeq_level_t host_hi;
		rxeq_level_t host_lo;
		logic aeq_n;
		logic [LANES-1:0][IDX_W-1:0] conn_sel;
		logic [IDX_W-1:0] host_sel;
		logic [LANES-1:0][IDX_W-1:0] long_sel;
		logic full_en;
		logic fast_en;
		logic ovr;
		logic sign;
		logic [1:0] lin;
		logic [IDX_W-1:0] upper;
		logic [IDX_W-1:0] ofs;
		logic [EYE_W-1:0] limits;
		logic [LANES-1:0] fast_wait;
		logic [LANES-1:0] fast_short;
		logic [DATA_W-1:0] rdata;
		logic [LANES-1:0][IDX_W-1:0] conn_out;
		logic [IDX_W-1:0] host_out;
		logic [1:0] lin_out;
		logic linear;
	} rxeq_state_s;
endpackage

// File: hdl/rxeq_sweep.sv
// module: full adaptation sweep engine for one connector receiver
`timescale 1ns/10ps
module rxeq_sweep
	import rxeq_pkg::*;
#(
	parameter int SETTLE = SETTLE_CYC
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// control
	input wire logic start_i,
	input wire logic [IDX_W-1:0] upper_i,
	// eye estimate
	input wire logic eye_valid_i,
	input wire logic [EYE_W-1:0] eye_i,
	// result
	output logic busy_o,
	output logic found_o,
	output logic [IDX_W-1:0] idx_o
);
	localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE - 1);

	rxeq_sweep_s s_r;
	rxeq_sweep_s s_nxt;

	// step the index upward, give each setting time to settle, then judge it
	always_comb
	begin
		s_nxt = s_r;
		case (s_r.st)
			SW_IDLE:
			begin
			end
			SW_SETTLE:
			begin
				if (s_r.cnt == '0)
					s_nxt.st = SW_MEASURE;
				else
					s_nxt.cnt = s_r.cnt - 1'b1;
			end
			SW_MEASURE:
			begin
				if (eye_valid_i)
				begin
					// strict compare keeps the lowest index on a tie
					if (s_r.idx == '0 || eye_i > s_r.best_eye)
					begin
						s_nxt.best = s_r.idx; // R5
						s_nxt.best_eye = eye_i;
					end
					if (s_r.idx >= upper_i)
					begin
						s_nxt.st = SW_IDLE; // R5
						s_nxt.found = 1'b1;
					end
					else
					begin
						s_nxt.idx = s_r.idx + 1'b1; // R5
						s_nxt.cnt = SETTLE_LOAD;
						s_nxt.st = SW_SETTLE;
					end
				end
			end
			default:
				s_nxt.st = SW_IDLE;
		endcase
		// a new insertion restarts the sweep from the lowest setting
		if (start_i)
		begin
			s_nxt.st = SW_SETTLE;
			s_nxt.idx = '0; // R5
			s_nxt.cnt = SETTLE_LOAD;
			s_nxt.found = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign busy_o = (s_r.st != SW_IDLE);
	assign found_o = s_r.found;
	assign idx_o = busy_o ? s_r.idx : s_r.best;
endmodule

// File: tb/rxeq_afe_model.sv
// file: behavioural front end of one connector lane giving eye estimates from the applied index
`timescale 1ns/10ps
module rxeq_afe_model
	import rxeq_pkg::*;
#(
	parameter int PERIOD = 6
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// bench control of the channel
	input wire logic go_i,
	input wire logic [IDX_W-1:0] target_i,
	input wire logic [EYE_W-1:0] peak_i,
	// applied setting and measurement bundle
	input wire logic [IDX_W-1:0] idx_i,
	output rxeq_meas_s meas_o
);
	int cnt;
	logic [EYE_W-1:0] pen;
	// each step away from the best index costs eight units of eye height
	always_comb
	begin
		pen = (idx_i > target_i) ? EYE_W'({idx_i - target_i, 3'h0}) : EYE_W'({target_i - idx_i, 3'h0});
	end
	// insertion pulse on request, one estimate every PERIOD cycles; the eye bus
	// toggles between estimates so that a stale value is never taken for data
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt <= 0;
			meas_o <= '0;
		end
		else
		begin
			meas_o.start <= go_i;
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			meas_o.valid <= (cnt == PERIOD - 1);
			meas_o.eye <= (cnt != PERIOD - 1) ? ~meas_o.eye : (peak_i > pen) ? peak_i - pen : 8'h00;
		end
	end
endmodule

// File: tb/rxeq_ctrl_tb_top.sv
// file: self-checking bench of the receiver eq select control with two lane models
`timescale 1ns/10ps
module rxeq_ctrl_tb_top
	import rxeq_pkg::*;
;
	typedef struct packed {
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] v;
		logic pc;
		logic [3:0] pv;
	} rxeq_note_s;
	// design inputs, all defined at time zero
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic en_i = 1'b0;
	logic aen_n = 1'b1;
	rxeq_level_t md = LVL_0, ch = LVL_0, cl = LVL_0, hh = LVL_0, hl = LVL_0;
	logic [ADDR_W-1:0] ra = 4'h0;
	logic [DATA_W-1:0] wd = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [1:0] go = 2'h0;
	logic [IDX_W-1:0] tgt [2] = '{4'h0, 4'h0};
	logic [EYE_W-1:0] pk [2] = '{8'h00, 8'h00};
	// a net, since each lane model drives its own element
	wire rxeq_meas_s [LANES-1:0] meas;
	logic [DATA_W-1:0] rdata;
	logic [IDX_W-1:0] c1, c2, hx;
	logic [1:0] lin;
	logic lmode, biasoff, resv;
	rxeq_note_s notes [$];
	rxeq_note_s n;
	logic rd_seen = 1'b0;
	int err_total = 0;
	int tests_run = 0;
	int seed = 32'hcd0a_1e78;
	logic [DATA_W-1:0] rv [3];
	logic [DATA_W-1:0] rst_v [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'h08, 8'h40};
	// {sweep reg, ctrl reg, lane one result, lane two result} with best 5 and 2
	logic [31:0] ofs_tab [6] = '{32'h0801_0502, 32'h3801_0805, 32'hA801_0F0C,
		32'hC801_0F0E, 32'h3809_0200, 32'h7809_0000};

	always #(CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;

	rxeq_ctrl #(.SETTLE(2)) rxeq_ctrl_i (
		.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .en_i(en_i), .mode_strap_i(md),
		.conn_eq_strap_high_i(ch), .conn_eq_strap_low_i(cl), .host_eq_strap_high_i(hh),
		.host_eq_strap_low_i(hl), .adaptive_enable_n_strap_i(aen_n), .reg_addr_i(ra),
		.reg_wdata_i(wd), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
		.conn_meas_i(meas), .conn_rx1_eq_index_o(c1), .conn_rx2_eq_index_o(c2),
		.host_rx_eq_index_o(hx), .tx_linearity_o(lin), .tx_linear_mode_o(lmode),
		.strap_bias_off_o(biasoff), .mode_reserved_o(resv));
	rxeq_afe_model afe0_i (.clk_i(ref_clk_i), .rst_n_i(nrst_i), .go_i(go[0]),
		.target_i(tgt[0]), .peak_i(pk[0]), .idx_i(c1), .meas_o(meas[0]));
	rxeq_afe_model afe1_i (.clk_i(ref_clk_i), .rst_n_i(nrst_i), .go_i(go[1]),
		.target_i(tgt[1]), .peak_i(pk[1]), .idx_i(c2), .meas_o(meas[1]));

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic cmp_byte(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: read data %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_port(input logic [3:0] got, input logic [3:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: output %h expected %h", $time, got, exp);
		end
	endtask

	// port that mirrors each output offset, status shows the reserved flag; other offsets show the transmitter controls and the strap bias flag
	function automatic logic [3:0] pview(input logic [ADDR_W-1:0] a);
		case (a)
			REG_CONN1_OUT: return c1;
			REG_CONN2_OUT: return c2;
			REG_HOST_OUT: return hx;
			REG_STATUS: return {3'h0, resv};
			default: return {lmode, biasoff, lin};
		endcase
	endfunction

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk_i);
		ra <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge ref_clk_i);
		wr_s <= 1'b0;
	endtask

	// the note goes in before the strobe; the monitor takes it a cycle after
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v,
		input logic pc = 1'b0, input logic [3:0] pv = 4'h0);
		notes.push_back('{a, v, pc, pv});
		@(posedge ref_clk_i);
		ra <= a;
		rd_s <= 1'b1;
		@(posedge ref_clk_i);
		rd_s <= 1'b0;
	endtask

	task automatic ck(input logic [ADDR_W-1:0] a, input logic [3:0] e);
		rd(a, {4'h0, e}, 1'b1, e);
	endtask

	// straps change with enable low; enable rises one edge later and the next edge latches them
	task automatic strap(input rxeq_level_t m, input logic [3:0] ci, input logic [3:0] hi,
		input logic an);
		@(posedge ref_clk_i);
		en_i <= 1'b0;
		md <= m;
		{ch, cl} <= ci;
		{hh, hl} <= hi;
		aen_n <= an;
		@(posedge ref_clk_i);
		en_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
	endtask

	// insertion on the chosen lanes; waits out the longest sweep of nine indices
	task automatic insert(input logic [1:0] m, input logic [3:0] t0, input logic [7:0] p0,
		input logic [3:0] t1, input logic [7:0] p1);
		@(posedge ref_clk_i);
		tgt[0] <= t0;
		pk[0] <= p0;
		tgt[1] <= t1;
		pk[1] <= p1;
		go <= m;
		@(posedge ref_clk_i);
		go <= 2'h0;
		repeat (100) @(posedge ref_clk_i);
	endtask

	// read data stand one cycle after the strobe
	always @(posedge ref_clk_i)
	begin
		if (rd_seen)
		begin
			n = notes.pop_front();
			cmp_byte(rdata, n.v);
			if (n.pc)
				cmp_port(pview(n.a), n.pv);
		end
		rd_seen <= rd_s;
	end

	// watchdog: the sequence needs about one thousand cycles
	initial
	begin
		repeat (20000) @(posedge ref_clk_i);
		err_total++;
		end_of_test();
	end

	initial
	begin
		repeat (8) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		// reset contents, read-only and unmapped places
		wr(REG_CONN1_OUT, 8'h0F);
		for (int i = 0; i < 7; i++)
			rd(ADDR_W'(i), rst_v[i]);
		rd(4'h7, 8'h00);
		ck(REG_CONN1_OUT, 4'h0);
		rd(REG_CTRL, 8'h30, 1'b1, 4'hB);
		// every connector strap combination, host straps reversed against the connector ones
		for (int i = 0; i < 16; i++)
		begin
			strap(LVL_0, 4'(i), 4'(15 - i), 1'b1);
			ck(REG_CONN1_OUT, 4'(i));
			ck(REG_CONN2_OUT, 4'(i));
			ck(REG_HOST_OUT, 4'(15 - i));
		end
		wr(REG_CONN1_SEL, 8'h02);
		wr(REG_CTRL, 8'h14);
		rd(REG_CTRL, 8'h14, 1'b1, 4'hF);
		ck(REG_CONN1_OUT, 4'hF);
		// both short flags read one: the fast judgement leaves reset as short
		rd(REG_STATUS, 8'h2C, 1'b1, 4'h0);
		wr(REG_CTRL, 8'h00);
		strap(LVL_R, 4'h6, 4'h3, 1'b1);
		rd(REG_STATUS, 8'h2C, 1'b1, 4'h1);
		strap(LVL_1, 4'h6, 4'h3, 1'b1);
		rd(REG_STATUS, 8'h2C, 1'b1, 4'h1);
		ck(REG_CONN1_OUT, 4'h6);
		// register mode: straps hold until the override is set
		strap(LVL_F, 4'h6, 4'h3, 1'b1);
		rd(REG_STATUS, 8'h3C, 1'b1, 4'h0);
		ck(REG_CONN1_OUT, 4'h6);
		ck(REG_HOST_OUT, 4'h3);
		for (int k = 0; k < 3; k++)
		begin
			rv[k] = 8'($random(seed)) & 8'h0F;
			wr(ADDR_W'(k), rv[k]);
		end
		wr(REG_CTRL, 8'h04);
		for (int k = 0; k < 3; k++)
		begin
			rd(ADDR_W'(k), rv[k]);
			ck(ADDR_W'(k + 8), rv[k][3:0]);
		end
		for (int l = 0; l < 4; l++)
		begin
			wr(REG_CTRL, {2'h0, 2'(l), 4'h4});
			rd(REG_CTRL, {2'h0, 2'(l), 4'h4}, 1'b1, {2'h3, 2'(l)});
		end
		// fast choice: short lane keeps its field, long lane moves to the long field
		wr(REG_CONN1_SEL, 8'h04);
		wr(REG_CONN2_SEL, 8'h09);
		wr(REG_LONG_SEL, 8'hC7);
		wr(REG_CTRL, 8'h06);
		insert(2'h3, 4'h4, 8'h50, 4'h9, 8'h30);
		ck(REG_CONN1_OUT, 4'h4);
		ck(REG_CONN2_OUT, 4'hC);
		wr(REG_LIMITS, 8'h60);
		insert(2'h1, 4'h4, 8'h50, 4'h9, 8'h30);
		ck(REG_CONN1_OUT, 4'h7);
		strap(LVL_0, 4'h6, 4'h3, 1'b1);
		// a strong eye would flip lane one to short if a judgement had started
		insert(2'h1, 4'h6, 8'h70, 4'h9, 8'h30);
		ck(REG_CONN1_OUT, 4'h6);
		rd(REG_STATUS, 8'h20, 1'b1, 4'h0);
		// full sweep enabled by the strap alone
		strap(LVL_0, 4'h6, 4'h3, 1'b0);
		insert(2'h1, 4'h5, 8'hC0, 4'h2, 8'hC0);
		ck(REG_CONN1_OUT, 4'h5);
		// full sweep in register mode, then every offset case on the kept result
		strap(LVL_F, 4'h6, 4'h3, 1'b1);
		wr(REG_CTRL, 8'h01);
		insert(2'h3, 4'h5, 8'hC0, 4'h2, 8'hC0);
		for (int t = 0; t < 6; t++)
		begin
			wr(REG_SWEEP, ofs_tab[t][31:24]);
			wr(REG_CTRL, ofs_tab[t][23:16]);
			ck(REG_CONN1_OUT, ofs_tab[t][11:8]);
			ck(REG_CONN2_OUT, ofs_tab[t][3:0]);
		end
		// a lower limit stops the sweep short of the best index
		wr(REG_SWEEP, 8'h03);
		wr(REG_CTRL, 8'h01);
		insert(2'h3, 4'h5, 8'hC0, 4'h2, 8'hC0);
		ck(REG_CONN1_OUT, 4'h3);
		ck(REG_CONN2_OUT, 4'h2);
		repeat (3) @(posedge ref_clk_i);
		end_of_test();
	end
endmodule
